// ===== sif_pkg.sv
// Purpose: Shared constants for the secondary interrupt flag block
// Assumes: 8-bit byte addresses on a 32-bit classic Wishbone bus
// Notes:   Registers hold byte-wide data in lane 0
package sif_pkg;

  // ==========================================================
  // Register word indices (byte address = index * 4)
  localparam logic [2:0] IDX_TIMER_ADC = 3'h0;
  localparam logic [2:0] IDX_GROUP = 3'h1;
  localparam logic [2:0] IDX_CONTROL = 3'h2;
  localparam logic [2:0] IDX_IRQ_STATUS = 3'h3;
  localparam logic [2:0] IDX_IRQ_CLEAR = 3'h4;
  localparam logic [2:0] IDX_IRQ_ENABLE = 3'h5;
  localparam logic [2:0] IDX_LAST = 3'h5;

  // ==========================================================
  // Timer / converter register fields
  localparam int T2F_BIT = 6;
  localparam int T0F_BIT = 5;
  localparam int T2E_BIT = 2;
  localparam int T0E_BIT = 1;
  localparam logic [7:0] TIMER_ADC_MASK = 8'h66;

  // ==========================================================
  // Shared group register fields
  localparam int T1F_BIT = 6;
  localparam int COMPARATOR2_REQUEST_FLAG_BIT = 5;
  localparam int COMPARATOR3_REQUEST_FLAG_BIT = 4;
  localparam int T1E_BIT = 2;
  localparam int COMPARATOR2_IRQ_ENABLE_BIT = 1;
  localparam int COMPARATOR3_IRQ_ENABLE_BIT = 0;
  localparam logic [7:0] GROUP_MASK = 8'h77;

  // ==========================================================
  // Control register fields
  localparam int GIE_BIT = 0;
  localparam int MFE_BIT = 1;
  localparam int MFF_BIT = 2;
  localparam int CONV_BIT = 3;
  localparam logic [7:0] CONTROL_WMASK = 8'h07;

  // ==========================================================
  // Event status bits, shared by status, clear and enable
  localparam int EV_W = 6;
  localparam int EV_T0 = 0;
  localparam int EV_SHARED = 1;
  localparam int EV_T1 = 2;
  localparam int EV_CP2 = 3;
  localparam int EV_CP3 = 4;
  localparam int EV_SERVICE = 5;

  // ==========================================================
  // Priority levels, highest first, and their vectors
  localparam int LVL_W = 5;
  localparam int LVL_GROUP = 0;
  localparam int LVL_CMP1 = 1;
  localparam int LVL_EXT = 2;
  localparam int LVL_T0 = 3;
  localparam int LVL_SHARED = 4;
  localparam logic [7:0] VEC_GROUP = 8'h04;
  localparam logic [7:0] VEC_CMP1 = 8'h08;
  localparam logic [7:0] VEC_EXT = 8'h0c;
  localparam logic [7:0] VEC_T0 = 8'h14;
  localparam logic [7:0] VEC_SHARED = 8'h18;

  // ==========================================================
  // Reset values
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [5:0] RESET_EV = 6'h00;

endpackage : sif_pkg

// ===== sif_reg_if.sv
// Purpose: Register access strobe between bus slave and core logic
// Assumes: One write pulse per accepted bus write
// Notes:   Read data is combinational from the core
`timescale 1ns/100ps
interface sif_reg_if;
  logic wr;
  logic [2:0] idx;
  logic [7:0] wdat;
  logic [7:0] rdat;

  modport slave (output wr, output idx, output wdat, input rdat);
  modport core (input wr, input idx, input wdat, output rdat);
endinterface : sif_reg_if

// ===== sif_wb_slave.sv
// Purpose: Classic Wishbone slave for the interrupt flag registers
// Assumes: Master holds the request until it samples ack
// Notes:   Ack one cycle after request; unmapped reads give zero
`timescale 1ns/100ps
module sif_wb_slave (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Core side
  sif_reg_if.slave reg_if
);
  typedef struct packed {
    logic ack;
    logic [7:0] dat;
  } sif_slave_type;

  sif_slave_type s;
  sif_slave_type next_s;
  logic take;
  logic bad;

  // ==========================================================
  // Decode
  always_comb begin
    take = wb_cyc_i & wb_stb_i & ~s.ack;
    bad = (wb_adr_i[7:5] != 3'h0) || (wb_adr_i[1:0] != 2'h0) ||
          (wb_adr_i[4:2] > sif_pkg::IDX_LAST);
    reg_if.idx = wb_adr_i[4:2];
    reg_if.wdat = wb_dat_i[7:0];
    // Lane 0 alone carries data; other lanes are ignored
    reg_if.wr = take & wb_we_i & wb_sel_i[0] & ~bad;
    next_s = s;
    next_s.ack = take;
    if (take) begin
      next_s.dat = (bad || wb_we_i) ? 8'h00 : reg_if.rdat;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign wb_ack_o = s.ack;
  assign wb_dat_o = {24'h000000, s.dat};

  a_ack_one_cycle: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o) else $error("ack held too long");
endmodule : sif_wb_slave

// ===== sif_prio.sv
// Purpose: Fixed priority pick among pending interrupt levels
// Assumes: Level 0 is the highest priority
// Notes:   Registered, so selection lags the pending set by a cycle
`timescale 1ns/100ps
module sif_prio (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Pending levels
  input wire logic [sif_pkg::LVL_W-1:0] pend_i,
  // Selection
  output logic [sif_pkg::LVL_W-1:0] sel_o,
  output logic [7:0] vector_o
);
  typedef struct packed {
    logic [sif_pkg::LVL_W-1:0] sel;
    logic [7:0] vec;
  } sif_prio_type;

  sif_prio_type s;
  sif_prio_type next_s;

  function automatic logic [7:0] lvl_vec(input int l);
    unique case (l)
      sif_pkg::LVL_GROUP: lvl_vec = sif_pkg::VEC_GROUP;
      sif_pkg::LVL_CMP1: lvl_vec = sif_pkg::VEC_CMP1;
      sif_pkg::LVL_EXT: lvl_vec = sif_pkg::VEC_EXT;
      sif_pkg::LVL_T0: lvl_vec = sif_pkg::VEC_T0;
      default: lvl_vec = sif_pkg::VEC_SHARED;
    endcase
  endfunction : lvl_vec

  // ==========================================================
  // Lowest index wins
  always_comb begin
    next_s = '0;
    for (int l = sif_pkg::LVL_W - 1; l >= 0; l--) begin
      if (pend_i[l]) begin
        next_s.sel = '0;
        next_s.sel[l] = 1'b1; // R16
        next_s.vec = lvl_vec(l);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign sel_o = s.sel;
  assign vector_o = s.vec;

  a_group_first: assert property (@(posedge clk_i) disable iff (rst_i)
    pend_i[sif_pkg::LVL_GROUP] |=> vector_o == 8'h04) // R16
    else $error("group level not chosen first");
  a_shared_last: assert property (@(posedge clk_i) disable iff (rst_i)
    pend_i == 5'h10 |=> vector_o == 8'h18) // R16
    else $error("shared level vector wrong");
endmodule : sif_prio

// ===== sif_top.sv
// Purpose: Second and shared-group interrupt request/enable registers
// Assumes: Source events are one-cycle pulses on clk_i
// Notes:   Core signals service_i when it takes the shown vector
//
// What this block does
// [R1] Shared timer2/converter request flag at bit 6
// [R2] Timer 0 request flag at bit 5
// [R3] Shared source enable at bit 2
// [R4] Timer 0 enable at bit 1
// [R5] Group register: timer 1 flag bit 6
// [R6] Group register: comparator 2 flag bit 5
// [R7] Group register: timer 1 enable bit 2
// [R8] Group register: comparator 2 enable bit 1
// [R9] Group register: comparator 3 enable bit 0
// [R10] Unimplemented bits read zero, ignore writes
// [R11] Option picks timer 2 or converter event
// [R12] Group register: comparator 3 flag bit 4
// [R13] All flags and enables clear at reset
// [R14] Enabled group requests set group flag; service clears
// [R15] Shared service clears its flag and global enable
// [R16] Fixed priority, group first, shared source last
`timescale 1ns/100ps
module sif_top (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Source events and option
  input wire logic timer0_ovf_i,
  input wire logic timer2_ovf_i,
  input wire logic conv_done_i,
  input wire logic timer1_evt_i,
  input wire logic cmp2_evt_i,
  input wire logic cmp3_evt_i,
  input wire logic conv_option_i,
  // Core side
  input wire logic cmp1_pending_i,
  input wire logic ext_pending_i,
  input wire logic service_i,
  output logic cpu_irq_req_o,
  output logic [7:0] vector_o,
  output logic irq_o
);
  typedef struct packed {
    logic timer2_or_conv_request_flag;
    logic timer0_request_flag;
    logic timer2_or_conv_irq_enable;
    logic timer0_irq_enable;
    logic timer1_request_flag;
    logic comparator2_request_flag;
    logic comparator3_request_flag;
    logic timer1_irq_enable;
    logic comparator2_irq_enable;
    logic comparator3_irq_enable;
    logic shared_group_request_flag;
    logic group_enable;
    logic global_irq_enable;
    logic conv_sel;
    logic cfg_done;
    logic grp_q;
    logic req;
    logic [sif_pkg::EV_W-1:0] sts;
    logic [sif_pkg::EV_W-1:0] ien;
    logic irq;
  } sif_state_type;

  sif_state_type s;
  sif_state_type next_s;
  sif_reg_if reg_if ();
  logic [sif_pkg::LVL_W-1:0] pend;
  logic [sif_pkg::LVL_W-1:0] sel;
  logic shared_evt;
  logic group_any;
  logic svc_group;
  logic svc_t0;
  logic svc_shared;
  logic [sif_pkg::EV_W-1:0] ev;

  // Hardware set wins over a clear in the same cycle
  function automatic logic upd(input logic cur, input logic wr,
                               input logic wval, input logic clr,
                               input logic set);
    logic v;
    v = wr ? wval : cur;
    if (clr) begin
      v = 1'b0;
    end
    upd = v | set;
  endfunction : upd

  function automatic logic wr_to(input logic [2:0] idx);
    wr_to = reg_if.wr && (reg_if.idx == idx);
  endfunction : wr_to

  // ==========================================================
  // Bus slave and priority pick
  sif_wb_slave u_slave (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o),
    .reg_if(reg_if)
  );

  sif_prio u_prio (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pend_i(pend),
    .sel_o(sel),
    .vector_o(vector_o)
  );

  // ==========================================================
  // Read mux
  always_comb begin
    reg_if.rdat = 8'h00; // R10
    unique case (reg_if.idx)
      sif_pkg::IDX_TIMER_ADC: begin
        reg_if.rdat[sif_pkg::T2F_BIT] = s.timer2_or_conv_request_flag;
        reg_if.rdat[sif_pkg::T0F_BIT] = s.timer0_request_flag;
        reg_if.rdat[sif_pkg::T2E_BIT] = s.timer2_or_conv_irq_enable;
        reg_if.rdat[sif_pkg::T0E_BIT] = s.timer0_irq_enable;
      end
      sif_pkg::IDX_GROUP: begin
        reg_if.rdat[sif_pkg::T1F_BIT] = s.timer1_request_flag;
        reg_if.rdat[sif_pkg::COMPARATOR2_REQUEST_FLAG_BIT] = s.comparator2_request_flag;
        reg_if.rdat[sif_pkg::COMPARATOR3_REQUEST_FLAG_BIT] = s.comparator3_request_flag;
        reg_if.rdat[sif_pkg::T1E_BIT] = s.timer1_irq_enable;
        reg_if.rdat[sif_pkg::COMPARATOR2_IRQ_ENABLE_BIT] = s.comparator2_irq_enable;
        reg_if.rdat[sif_pkg::COMPARATOR3_IRQ_ENABLE_BIT] = s.comparator3_irq_enable;
      end
      sif_pkg::IDX_CONTROL: begin
        reg_if.rdat[sif_pkg::GIE_BIT] = s.global_irq_enable;
        reg_if.rdat[sif_pkg::MFE_BIT] = s.group_enable;
        reg_if.rdat[sif_pkg::MFF_BIT] = s.shared_group_request_flag;
        reg_if.rdat[sif_pkg::CONV_BIT] = s.conv_sel;
      end
      sif_pkg::IDX_IRQ_STATUS: reg_if.rdat[sif_pkg::EV_W-1:0] = s.sts;
      sif_pkg::IDX_IRQ_ENABLE: reg_if.rdat[sif_pkg::EV_W-1:0] = s.ien;
      default: reg_if.rdat = 8'h00;
    endcase
  end

  // ==========================================================
  // Events, pending levels and service decode
  always_comb begin
    // Option is latched once, so a late change cannot re-route
    shared_evt = s.conv_sel ? conv_done_i : timer2_ovf_i; // R11
    group_any = (s.timer1_request_flag & s.timer1_irq_enable) |
                (s.comparator2_request_flag & s.comparator2_irq_enable) |
                (s.comparator3_request_flag &
                 s.comparator3_irq_enable); // R14
    pend = '0;
    pend[sif_pkg::LVL_GROUP] = s.shared_group_request_flag &
                               s.group_enable;
    pend[sif_pkg::LVL_CMP1] = cmp1_pending_i;
    pend[sif_pkg::LVL_EXT] = ext_pending_i;
    pend[sif_pkg::LVL_T0] = s.timer0_request_flag & s.timer0_irq_enable;
    pend[sif_pkg::LVL_SHARED] = s.timer2_or_conv_request_flag &
                                s.timer2_or_conv_irq_enable;
    svc_group = service_i & s.req & sel[sif_pkg::LVL_GROUP];
    svc_t0 = service_i & s.req & sel[sif_pkg::LVL_T0];
    svc_shared = service_i & s.req & sel[sif_pkg::LVL_SHARED];
    ev = '0;
    ev[sif_pkg::EV_T0] = timer0_ovf_i;
    ev[sif_pkg::EV_SHARED] = shared_evt;
    ev[sif_pkg::EV_T1] = timer1_evt_i;
    ev[sif_pkg::EV_CP2] = cmp2_evt_i;
    ev[sif_pkg::EV_CP3] = cmp3_evt_i;
    ev[sif_pkg::EV_SERVICE] = service_i & s.req;
  end

  // ==========================================================
  // Next state
  always_comb begin
    logic wt;
    logic wg;
    logic wc;
    wt = wr_to(sif_pkg::IDX_TIMER_ADC);
    wg = wr_to(sif_pkg::IDX_GROUP);
    wc = wr_to(sif_pkg::IDX_CONTROL);
    next_s = s;
    if (!s.cfg_done) begin
      next_s.conv_sel = conv_option_i; // R11
      next_s.cfg_done = 1'b1;
    end
    next_s.timer2_or_conv_request_flag = upd(
      s.timer2_or_conv_request_flag, wt,
      reg_if.wdat[sif_pkg::T2F_BIT], svc_shared, shared_evt); // R1 R15
    next_s.timer0_request_flag = upd(s.timer0_request_flag, wt,
      reg_if.wdat[sif_pkg::T0F_BIT], svc_t0, timer0_ovf_i); // R2
    if (wt) begin
      next_s.timer2_or_conv_irq_enable =
        reg_if.wdat[sif_pkg::T2E_BIT]; // R3
      next_s.timer0_irq_enable = reg_if.wdat[sif_pkg::T0E_BIT]; // R4
    end
    next_s.timer1_request_flag = upd(s.timer1_request_flag, wg,
      reg_if.wdat[sif_pkg::T1F_BIT], 1'b0, timer1_evt_i); // R5
    next_s.comparator2_request_flag = upd(s.comparator2_request_flag,
      wg, reg_if.wdat[sif_pkg::COMPARATOR2_REQUEST_FLAG_BIT], 1'b0, cmp2_evt_i); // R6
    next_s.comparator3_request_flag = upd(s.comparator3_request_flag,
      wg, reg_if.wdat[sif_pkg::COMPARATOR3_REQUEST_FLAG_BIT], 1'b0, cmp3_evt_i); // R12
    if (wg) begin
      next_s.timer1_irq_enable = reg_if.wdat[sif_pkg::T1E_BIT]; // R7
      next_s.comparator2_irq_enable =
        reg_if.wdat[sif_pkg::COMPARATOR2_IRQ_ENABLE_BIT]; // R8
      next_s.comparator3_irq_enable =
        reg_if.wdat[sif_pkg::COMPARATOR3_IRQ_ENABLE_BIT]; // R9
    end
    // Group flag follows a rise of the enabled OR, not its level
    next_s.grp_q = group_any;
    next_s.shared_group_request_flag = upd(
      s.shared_group_request_flag, wc, reg_if.wdat[sif_pkg::MFF_BIT],
      svc_group, group_any & ~s.grp_q); // R14
    if (wc) begin
      next_s.group_enable = reg_if.wdat[sif_pkg::MFE_BIT];
    end
    next_s.global_irq_enable = upd(s.global_irq_enable, wc,
      reg_if.wdat[sif_pkg::GIE_BIT], service_i & s.req, 1'b0); // R15
    next_s.req = next_s.global_irq_enable & (|pend); // R16
    next_s.sts = (s.sts & ~(wr_to(sif_pkg::IDX_IRQ_CLEAR) ?
                  reg_if.wdat[sif_pkg::EV_W-1:0] : sif_pkg::RESET_EV))
                 | ev;
    if (wr_to(sif_pkg::IDX_IRQ_ENABLE)) begin
      next_s.ien = reg_if.wdat[sif_pkg::EV_W-1:0];
    end
    next_s.irq = |(s.sts & s.ien);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '0; // R13
    end else begin
      s <= next_s;
    end
  end

  assign cpu_irq_req_o = s.req;
  assign irq_o = s.irq;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence shared_taken;
    service_i && s.req && sel[sif_pkg::LVL_SHARED] && !shared_evt;
  endsequence

  sequence shared_cleared;
    !s.timer2_or_conv_request_flag && !s.global_irq_enable;
  endsequence

  a_shared_service: assert property (
    shared_taken |=> shared_cleared) // R15
    else $error("shared service did not clear flag and enable");
  a_shared_flag_set: assert property (
    shared_evt |=> s.timer2_or_conv_request_flag) // R1
    else $error("shared flag not set by event");
  a_timer_source: assert property (
    s.cfg_done && !s.conv_sel && timer2_ovf_i
    |=> s.timer2_or_conv_request_flag) // R11
    else $error("timer 2 event not routed");
  a_t0_flag_set: assert property (
    timer0_ovf_i |=> s.timer0_request_flag) // R2
    else $error("timer 0 flag lost");
  a_enable_write: assert property (
    wr_to(sif_pkg::IDX_TIMER_ADC) |=>
    s.timer2_or_conv_irq_enable == $past(reg_if.wdat[2]) &&
    s.timer0_irq_enable == $past(reg_if.wdat[1])) // R3 R4
    else $error("timer register enables not written");
  a_group_enables: assert property (
    wr_to(sif_pkg::IDX_GROUP) |=>
    {s.timer1_irq_enable, s.comparator2_irq_enable,
     s.comparator3_irq_enable} == $past(reg_if.wdat[2:0])) // R7 R8 R9
    else $error("group enables not written");
  a_group_flags: assert property (
    timer1_evt_i || cmp2_evt_i || cmp3_evt_i |=>
    ({s.timer1_request_flag, s.comparator2_request_flag,
      s.comparator3_request_flag} &
     $past({timer1_evt_i, cmp2_evt_i, cmp3_evt_i})) ==
    $past({timer1_evt_i, cmp2_evt_i, cmp3_evt_i})) // R5 R6 R12
    else $error("group flags not set");
  a_unused_zero: assert property (
    (reg_if.idx == sif_pkg::IDX_TIMER_ADC ? (reg_if.rdat & 8'h99) :
     reg_if.idx == sif_pkg::IDX_GROUP ? (reg_if.rdat & 8'h88) :
     8'h00) == 8'h00) // R10
    else $error("unimplemented bit reads one");
  a_group_rise: assert property (
    group_any && !s.grp_q |=> s.shared_group_request_flag) // R14
    else $error("group flag not raised");
  a_reset_clear: assert property (disable iff (1'b0)
    rst_i |=> s.sts == 6'h00 && !s.timer0_request_flag &&
    !s.global_irq_enable && !irq_o) // R13
    else $error("reset left state set");
  a_irq_level: assert property (
    (|(s.sts & s.ien)) |=> irq_o)
    else $error("interrupt output not raised");
endmodule : sif_top

// ===== tb.sv
// Purpose: Self-checking bench for the secondary interrupt flag block
// Assumes: Ack one cycle after request, registered core outputs
// Notes:   Random data from a fixed seed, corner cases written by hand
`timescale 1ns/100ps
module tb;
  // ==========================================================
  // Signals
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic [5:0] ev = 6'h00;
  logic conv_option_i = 1'b0;
  logic cmp1_pending_i = 1'b0;
  logic ext_pending_i = 1'b0;
  logic service_i = 1'b0;
  logic cpu_irq_req_o;
  logic [7:0] vector_o;
  logic irq_o;
  int fails = 0;
  int num_checks = 0;
  int cycles = 0;
  int seed = 83081;
  logic [31:0] rd;
  logic [7:0] r;

  always #25 clk_i = ~clk_i;

  sif_top u_dut (
    .clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .timer0_ovf_i(ev[0]), .timer2_ovf_i(ev[1]), .conv_done_i(ev[2]),
    .timer1_evt_i(ev[3]), .cmp2_evt_i(ev[4]), .cmp3_evt_i(ev[5]),
    .conv_option_i(conv_option_i),
    .cmp1_pending_i(cmp1_pending_i), .ext_pending_i(ext_pending_i),
    .service_i(service_i), .cpu_irq_req_o(cpu_irq_req_o),
    .vector_o(vector_o), .irq_o(irq_o)
  );

  // ==========================================================
  // Checking and closing
  task automatic check(input string nm, input logic [31:0] exp,
                       input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : check

  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : end_sim

  // Ceiling well above the few hundred cycles the tests need
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      $display("[ERR] run timeout expected 0 seen %0d", cycles);
      end_sim();
    end
  end

  // ==========================================================
  // Bus and stimulus tasks
  task automatic wb(input logic we, input logic [7:0] adr,
                    input logic [7:0] d, input logic [3:0] sel);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_sel_i <= sel;
    wb_dat_i <= {24'($random(seed)), d};
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    rd = wb_dat_o;
    if (n >= 50) check("bus ack", 32'h1, 32'h0);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask : wb

  task automatic wr(input logic [7:0] adr, input logic [7:0] d);
    wb(1'b1, adr, d, 4'h1);
  endtask : wr

  task automatic rchk(input string nm, input logic [7:0] adr,
                      input logic [7:0] exp);
    wb(1'b0, adr, 8'h00, 4'hf);
    check(nm, {24'h0, exp}, rd);
  endtask : rchk

  task automatic pulse(input logic [5:0] m);
    @(posedge clk_i);
    ev <= m;
    @(posedge clk_i);
    ev <= 6'h00;
  endtask : pulse

  task automatic do_reset(input logic opt);
    @(posedge clk_i);
    rst_i <= 1'b1;
    conv_option_i <= opt;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
  endtask : do_reset

  task automatic serve(input logic [7:0] vec);
    int n;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (cpu_irq_req_o !== 1'b1 && n < 20);
    check("request", 32'h1, {31'h0, cpu_irq_req_o});
    check("vector", {24'h0, vec}, {24'h0, vector_o});
    service_i <= 1'b1;
    @(posedge clk_i);
    service_i <= 1'b0;
    repeat (2) @(posedge clk_i);
  endtask : serve

  function automatic logic [7:0] reg_mask(input logic [7:0] adr);
    return (adr == 8'h00) ? 8'h66 : 8'h77;
  endfunction : reg_mask

  // ==========================================================
  // Main sequence
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    // Reset values of every register
    for (int a = 0; a < 6; a++)
      rchk("reset value", 8'(a * 4), 8'h00);
    $display("test reset done");

    // Random writes, masked read back; bits without a field stay zero
    for (int i = 0; i < 16; i++) begin
      logic [7:0] a;
      // Last write lands in the timer register, checked below
      a = (i % 2 == 0) ? 8'h04 : 8'h00;
      r = 8'($random(seed));
      if (i < 2) r = 8'hff;
      wr(a, r);
      rchk("rw", a, r & reg_mask(a));
    end
    wb(1'b1, 8'h00, 8'h00, 4'he);
    rchk("sel low ignored", 8'h00, r & 8'h66 | 8'h00);
    wr(8'h18, 8'hff);
    rchk("unmapped", 8'h18, 8'h00);
    rchk("clear reads zero", 8'h10, 8'h00);
    $display("test registers done");

    // Option picks the shared source, for both settings
    for (int o = 1; o >= 0; o--) begin
      do_reset(o[0]);
      pulse(o[0] ? 6'h02 : 6'h04);
      rchk("unselected source", 8'h00, 8'h00);
      pulse(o[0] ? 6'h04 : 6'h02);
      rchk("selected source", 8'h00, 8'h40);
      rchk("option bit", 8'h08, o[0] ? 8'h08 : 8'h00);
    end
    $display("test option done");

    // Group flags, group service, status, enable and clear
    do_reset(1'b0);
    pulse(6'h30);
    rchk("cmp flags", 8'h04, 8'h30);
    // Keep the comparator flags, enable timer 1 alone
    wr(8'h04, 8'h34);
    wr(8'h08, 8'h03);
    pulse(6'h08);
    rchk("group flag", 8'h08, 8'h07);
    serve(sif_pkg::VEC_GROUP);
    rchk("after group service", 8'h08, 8'h02);
    rchk("flags stay", 8'h04, 8'h74);
    rchk("status", 8'h0c, 8'h3c);
    check("irq masked", 32'h0, {31'h0, irq_o});
    wr(8'h14, 8'h04);
    repeat (2) @(posedge clk_i);
    check("irq raised", 32'h1, {31'h0, irq_o});
    wr(8'h10, 8'h3f);
    repeat (2) @(posedge clk_i);
    check("irq cleared", 32'h0, {31'h0, irq_o});
    rchk("status cleared", 8'h0c, 8'h00);
    $display("test group done");

    // Priority among comparator 1, outside level, timer 0 and the shared source
    wr(8'h04, 8'h00);
    wr(8'h00, 8'h06);
    wr(8'h08, 8'h01);
    cmp1_pending_i <= 1'b1;
    ext_pending_i <= 1'b1;
    pulse(6'h03);
    repeat (2) @(posedge clk_i);
    check("comparator first", {24'h0, sif_pkg::VEC_CMP1},
          {24'h0, vector_o});
    cmp1_pending_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    check("outside first", {24'h0, sif_pkg::VEC_EXT},
          {24'h0, vector_o});
    ext_pending_i <= 1'b0;
    // Request stays high, so let the vector settle before serving
    repeat (2) @(posedge clk_i);
    serve(sif_pkg::VEC_T0);
    rchk("timer0 served", 8'h00, 8'h46);
    rchk("global cleared", 8'h08, 8'h00);
    wr(8'h08, 8'h01);
    serve(sif_pkg::VEC_SHARED);
    rchk("shared served", 8'h00, 8'h06);
    rchk("global cleared", 8'h08, 8'h00);
    $display("test priority done");
    end_sim();
  end
endmodule : tb
